// >>> rail3_pkg.sv
/*
  Shared constants and types for the third rail's voltage and sleep register block.
  Assumes a single 50 MHz clock domain and 8-bit register offsets.
*/
`default_nettype none
package rail3_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DECAY_OFFSET  = 8'h22;
  localparam logic [7:0] NORMAL_OFFSET = 8'h23;
  localparam logic [7:0] SLEEP_OFFSET  = 8'h24;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CODE_LSB     = 1;
  localparam int CODE_MSB     = 7;
  localparam int DECAY_BIT    = 0;
  localparam int SLEEP_EN_BIT = 0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Default factory contents (overridden per variant)
  // ----------------------------------------------------------------
  localparam logic [7:0] DECAY_RESET  = 8'h40;
  localparam logic [7:0] NORMAL_RESET = 8'h40;
  localparam logic [7:0] SLEEP_RESET  = 8'h40;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 50;
  localparam int SLEW_STEP_NS      = 1000;
  localparam int SLEW_STEP_CYCLES  = (SLEW_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int DECAY_HOLD_US     = 100;
  localparam int DECAY_HOLD_CYCLES = DECAY_HOLD_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic { SEL_PIN_THREE, SEL_PIN_SIX } sleep_pin_sel_t;
  typedef enum logic { STEP_10MV, STEP_25MV } step_scale_t;
  typedef enum logic [1:0] { ST_HOLD, ST_SLEW, ST_DECAY } drive_state_t;
endpackage : rail3_pkg
`default_nettype wire

// >>> sleep_pin_sync.sv
/*
  Synchroniser and factory selection of the sleep request pin.
  Assumes both control inputs are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
module sleep_pin_sync
  import rail3_pkg::*;
#(
  parameter sleep_pin_sel_t PIN_SEL = SEL_PIN_THREE
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic control_input_three_sleep_select_one,
  input  wire logic control_input_six_sleep_select_two,
  output var  logic sleep_pin_low
);
  logic [1:0] meta;
  logic [1:0] synced;

  // ----------------------------------------------------------------
  // Two-stage synchronisers; first stage is read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta   <= 2'h3;
      synced <= 2'h3;
    end else begin
      meta   <= {control_input_six_sleep_select_two, control_input_three_sleep_select_one};
      synced <= meta;
    end
  end

  // Fixed at build time, so software has no way to move the pin
  assign sleep_pin_low = (PIN_SEL == SEL_PIN_SIX) ? ~synced[1] : ~synced[0];
endmodule : sleep_pin_sync
`default_nettype wire

// >>> rail3_voltage_sleep_regs.sv
/*
  Register bank and target selection for the third step-down rail: decay select,
  normal code, sleep code with enable, and the down-slew or passive-decay sequencer.
  Assumes a simple synchronous register port from the serial interface and that the
  analog loop consumes regulation_code, step_25mv and passive_decay.
  Limitations: rises are applied in one step; the decay window is a fixed count
  rather than a measured fall; the code-to-voltage tables sit on the analog side,
  which reads step_25mv to pick its scale.
*/
//
// Contract
// - Decay bit 0: step down by controlled slewing
// - Decay bit 1: release drive, let output decay
// - Decay bits 7:1 spare storage, no effect
// - Voltage bits 7:1 normal target; bit 0 reads zero
// - Factory scale 10 mV or 25 mV, shared
// - Sleep bits 7:1 sleep target when enabled
// - Sleep enable 0: always normal code
// - Sleep enable 1: sleep code while pin low
// - Sleep pin fixed by factory, not software
// - Reset contents are factory variant defaults
`timescale 1ns/1ps
`default_nettype none
module rail3_voltage_sleep_regs
  import rail3_pkg::*;
#(
  parameter logic [7:0]     DECAY_INIT  = DECAY_RESET,
  parameter logic [7:0]     NORMAL_INIT = NORMAL_RESET,
  parameter logic [7:0]     SLEEP_INIT  = SLEEP_RESET,
  parameter sleep_pin_sel_t PIN_SEL     = SEL_PIN_THREE,
  parameter step_scale_t    STEP_SCALE  = STEP_10MV,
  parameter int             DECAY_HOLD  = DECAY_HOLD_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output var  logic [7:0] reg_rd_data,
  input  wire logic       control_input_three_sleep_select_one,
  input  wire logic       control_input_six_sleep_select_two,
  output var  logic [6:0] regulation_code,
  output var  logic [6:0] target_code,
  output var  logic       step_25mv,
  output var  logic       sleep_active,
  output var  logic       slew_active,
  output var  logic       passive_decay
);
  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------
  logic [7:0]   rail3_decay_select;
  logic [6:0]   rail3_normal_voltage_code;
  logic [7:0]   rail3_sleep_voltage_control;
  logic         sleep_pin_low;
  logic         hit_decay;
  logic         hit_normal;
  logic         hit_sleep;
  logic [7:0]   read_mux;
  logic         rail3_decay_select_bit;
  logic         rail3_sleep_enable;
  logic [6:0]   rail3_sleep_voltage_code;
  drive_state_t state;
  drive_state_t next_state;
  logic [6:0]   next_code;
  logic [15:0]  count;
  logic [15:0]  next_count;

  localparam logic [15:0] SLEW_LAST  = 16'(SLEW_STEP_CYCLES - 1);
  localparam logic [15:0] DECAY_LAST = 16'(DECAY_HOLD - 1);

  // Pin choice is a build parameter only; no register reaches it
  // Its flops start high, so a pin held low through reset counts two edges later
  sleep_pin_sync #(
    .PIN_SEL (PIN_SEL)
  ) u_sleep_pin (
    .clk                                  (clk),
    .arst_n                               (arst_n),
    .control_input_three_sleep_select_one (control_input_three_sleep_select_one),
    .control_input_six_sleep_select_two   (control_input_six_sleep_select_two),
    .sleep_pin_low                        (sleep_pin_low)
  );

  // Address decode for the three registers
  // Unmapped offsets match no hit, so their writes are simply dropped
  assign hit_decay  = (reg_addr == DECAY_OFFSET);
  assign hit_normal = (reg_addr == NORMAL_OFFSET);
  assign hit_sleep  = (reg_addr == SLEEP_OFFSET);

  // Field views; the spare bits are stored and read back but steer nothing
  assign rail3_decay_select_bit   = rail3_decay_select[DECAY_BIT];
  assign rail3_sleep_enable       = rail3_sleep_voltage_control[SLEEP_EN_BIT];
  assign rail3_sleep_voltage_code = rail3_sleep_voltage_control[CODE_MSB:CODE_LSB];

  // Read path; reserved bit 0 of the normal register always reads zero
  always_comb begin
    if (hit_decay) begin
      read_mux = rail3_decay_select;
    end else if (hit_normal) begin
      read_mux = {rail3_normal_voltage_code, 1'b0};
    end else if (hit_sleep) begin
      read_mux = rail3_sleep_voltage_control;
    end else begin
      read_mux = UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and read data
  // ----------------------------------------------------------------
  // Reset loads the per-variant factory image, not one fixed word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rail3_decay_select          <= DECAY_INIT;
      rail3_normal_voltage_code   <= NORMAL_INIT[CODE_MSB:CODE_LSB];
      rail3_sleep_voltage_control <= SLEEP_INIT;
      reg_rd_data                 <= 8'h00;
    end else begin
      if (reg_wr_en && hit_decay) begin
        rail3_decay_select <= reg_wr_data;
      end
      if (reg_wr_en && hit_normal) begin
        rail3_normal_voltage_code <= reg_wr_data[CODE_MSB:CODE_LSB];
      end
      if (reg_wr_en && hit_sleep) begin
        rail3_sleep_voltage_control <= reg_wr_data;
      end
      if (reg_rd_en) begin
        reg_rd_data <= read_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Target selection
  // ----------------------------------------------------------------
  // Purely combinational, so pin edges and writes take effect with no software step
  assign sleep_active = rail3_sleep_enable && sleep_pin_low;
  assign target_code  = sleep_active ? rail3_sleep_voltage_code
                                     : rail3_normal_voltage_code;
  // One scale for both code fields, fixed at build time
  assign step_25mv    = (STEP_SCALE == STEP_25MV);

  // ----------------------------------------------------------------
  // Down-transition sequencer
  // ----------------------------------------------------------------
  // Rises are applied at once; falls either walk one code per step or jump with
  // the drive released. The decay hold is a fixed window since the real fall rate
  // depends on load and capacitance that the logic cannot see.
  always_comb begin
    next_state = state;
    next_code  = regulation_code;
    next_count = count;
    case (state)
      ST_HOLD: begin
        next_count = 16'h0000;
        if (target_code > regulation_code) begin
          next_code = target_code;
        end else if (target_code < regulation_code) begin
          if (!rail3_decay_select_bit) begin
            next_state = ST_SLEW;
          end else begin
            next_code  = target_code;
            next_state = ST_DECAY;
          end
        end
      end
      ST_SLEW: begin
        // A raise or a reached target ends the walk at once
        if (target_code >= regulation_code) begin
          next_code  = target_code;
          next_state = ST_HOLD;
        end else if (count == SLEW_LAST) begin
          next_code  = regulation_code - 7'h01;
          next_count = 16'h0000;
        end else begin
          next_count = count + 16'h0001;
        end
      end
      ST_DECAY: begin
        // A further fall restarts the window from the new code
        if (target_code > regulation_code) begin
          next_code  = target_code;
          next_state = ST_HOLD;
        end else if (target_code < regulation_code) begin
          next_code  = target_code;
          next_count = 16'h0000;
        end else if (count == DECAY_LAST) begin
          next_state = ST_HOLD;
        end else begin
          next_count = count + 16'h0001;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  // Sequencer state
  // The applied code restarts at the normal code; a sleep target is reached by a rise or a fall from it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= ST_HOLD;
      regulation_code <= NORMAL_INIT[CODE_MSB:CODE_LSB];
      count           <= 16'h0000;
    end else begin
      state           <= next_state;
      regulation_code <= next_code;
      count           <= next_count;
    end
  end

  // Active pull-down only while slewing; released in the decay window
  assign slew_active   = (state == ST_SLEW);
  assign passive_decay = (state == ST_DECAY);
endmodule : rail3_voltage_sleep_regs
`default_nettype wire

// >>> rail3_asserts.sv
/*
  Checker for the third rail register block, bound to its top module.
  Assumes one clock domain and the sleep pin chosen by PIN_SEL.
*/
`timescale 1ns/1ps
`default_nettype none
module rail3_asserts
  import rail3_pkg::*;
#(
  parameter sleep_pin_sel_t PIN_SEL    = SEL_PIN_THREE,
  parameter step_scale_t    STEP_SCALE = STEP_10MV,
  parameter logic [7:0]     DECAY_INIT = DECAY_RESET,
  parameter logic [7:0]     SLEEP_INIT = SLEEP_RESET
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       control_input_three_sleep_select_one,
  input wire logic       control_input_six_sleep_select_two,
  input wire logic [6:0] regulation_code,
  input wire logic [6:0] target_code,
  input wire logic       step_25mv,
  input wire logic       sleep_active,
  input wire logic       slew_active,
  input wire logic       passive_decay
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Only the factory pin may request sleep; the other is never looked at
  wire logic sel_pin = (PIN_SEL == SEL_PIN_THREE) ? control_input_three_sleep_select_one
                                                  : control_input_six_sleep_select_two;
  wire logic mapped  = (reg_addr >= DECAY_OFFSET) && (reg_addr <= SLEEP_OFFSET);
  logic      decay_shadow;
  logic      sleep_en_shadow;

  // Shadows of the two control bits, rebuilt from the write port alone so the
  // checks below do not lean on the design's own storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      decay_shadow    <= DECAY_INIT[DECAY_BIT];
      sleep_en_shadow <= SLEEP_INIT[SLEEP_EN_BIT];
    end else begin
      if (reg_wr_en && reg_addr == DECAY_OFFSET) begin
        decay_shadow <= reg_wr_data[DECAY_BIT];
      end
      if (reg_wr_en && reg_addr == SLEEP_OFFSET) begin
        sleep_en_shadow <= reg_wr_data[SLEEP_EN_BIT];
      end
    end
  end

  a_rise_applied: assert property (target_code > regulation_code
    && !slew_active && !passive_decay |=> regulation_code == $past(target_code))
    else $error("rise not applied");
  a_slew_one_step: assert property (slew_active && target_code < regulation_code
    |=> regulation_code == $past(regulation_code)
    || regulation_code + 7'h01 == $past(regulation_code)) else $error("slew jump");
  a_slew_on_clear: assert property ($rose(slew_active) |-> !$past(decay_shadow))
    else $error("slew with decay bit set");
  a_decay_jump: assert property ($rose(passive_decay)
    |-> regulation_code == $past(target_code)) else $error("decay entry code");
  a_decay_on_set: assert property ($rose(passive_decay) |-> $past(decay_shadow))
    else $error("decay with decay bit clear");
  a_modes_apart: assert property (!(slew_active && passive_decay)) else $error("two modes");
  a_pin_high_awake: assert property (sel_pin [*3] |-> !sleep_active)
    else $error("sleep with pin high");
  // Four samples, so the attempt that starts on the release edge sees running flops
  a_pin_low_sleeps: assert property ((!sel_pin) [*4] ##0 sleep_en_shadow
    |-> sleep_active) else $error("no sleep with pin low");
  a_sleep_gated: assert property (!sleep_en_shadow |-> !sleep_active)
    else $error("sleep while disabled");
  a_scale_fixed: assert property (step_25mv == (STEP_SCALE == STEP_25MV))
    else $error("scale wrong");
  a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rd_data == 8'h00)
    else $error("unmapped read");
  a_vid_bit_zero: assert property (reg_rd_en && reg_addr == NORMAL_OFFSET
    |=> !reg_rd_data[0]) else $error("reserved bit set");
  a_read_holds: assert property (!reg_rd_en |=> $stable(reg_rd_data))
    else $error("rd moved");
  c_slew: cover property ($rose(slew_active));
  c_decay: cover property ($rose(passive_decay));
  c_sleep: cover property ($rose(sleep_active));
endmodule : rail3_asserts
bind rail3_voltage_sleep_regs rail3_asserts #(
  .PIN_SEL    (PIN_SEL),
  .STEP_SCALE (STEP_SCALE),
  .DECAY_INIT (DECAY_INIT),
  .SLEEP_INIT (SLEEP_INIT)
) chk (.*);
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the third rail register block.
  Assumes the strobe register port and a small DECAY_HOLD of 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rail3_pkg::*;
  logic clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, pin3 = 1, pin6 = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [6:0] reg_code, tgt_code;
  logic       s25, sleep_on, slewing, decaying;
  logic [6:0] tgt_six;
  logic       s25_six, sleep_six;
  int         err_total = 0, total_checks = 0;
  rail3_voltage_sleep_regs #(.DECAY_HOLD(8)) uut (.clk(clk), .arst_n(arst_n),
    .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(rd_en),
    .reg_rd_data(rdata), .control_input_three_sleep_select_one(pin3),
    .control_input_six_sleep_select_two(pin6), .regulation_code(reg_code),
    .target_code(tgt_code), .step_25mv(s25), .sleep_active(sleep_on),
    .slew_active(slewing), .passive_decay(decaying));
  // Second variant: sleep on pin six and the 25 mV scale
  rail3_voltage_sleep_regs #(.DECAY_HOLD(8), .PIN_SEL(SEL_PIN_SIX), .STEP_SCALE(STEP_25MV))
    uut_six (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wdata), .reg_rd_en(rd_en), .reg_rd_data(),
    .control_input_three_sleep_select_one(pin3),
    .control_input_six_sleep_select_two(pin6), .regulation_code(),
    .target_code(tgt_six), .step_25mv(s25_six), .sleep_active(sleep_six),
    .slew_active(), .passive_decay());
  always #10 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
    @(posedge clk) wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
    @(posedge clk) rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic results;
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Watchdog: the slow slew dominates, roughly 6000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(DECAY_OFFSET, DECAY_RESET);
    rd(NORMAL_OFFSET, NORMAL_RESET);
    rd(SLEEP_OFFSET, SLEEP_RESET);
    wr(DECAY_OFFSET, 8'hFF);
    rd(DECAY_OFFSET, 8'hFF);
    wr(NORMAL_OFFSET, 8'hFF);
    rd(NORMAL_OFFSET, 8'hFE);
    wr(8'h25, 8'h5A);
    rd(8'h25, 8'h00);
    wait_cyc(2);
    chk({1'b0, reg_code}, 8'h7F);
    // Pin low but sleep disabled: normal code must stay
    @(posedge clk) pin3 <= 1'b0;
    wr(SLEEP_OFFSET, 8'h20);
    wait_cyc(4);
    chk({1'b0, tgt_code}, 8'h7F);
    chk({7'h00, sleep_on}, 8'h00);
    wr(SLEEP_OFFSET, 8'h21);
    wait_cyc(1);
    chk({1'b0, tgt_code}, 8'h10);
    chk({7'h00, decaying}, 8'h01);
    chk({1'b0, reg_code}, 8'h10);
    chk({7'h00, sleep_six}, 8'h00);
    // Window is DECAY_HOLD = 8 cycles: still released at its last, held after
    wait_cyc(7);
    chk({7'h00, decaying}, 8'h01);
    wait_cyc(1);
    chk({7'h00, decaying}, 8'h00);
    // Only the other pin low: no sleep on uut, sleep on the pin-six variant
    @(posedge clk) begin pin3 <= 1'b1; pin6 <= 1'b0; end
    wait_cyc(4);
    chk({7'h00, sleep_on}, 8'h00);
    chk({1'b0, reg_code}, 8'h7F);
    chk({7'h00, sleep_six}, 8'h01);
    chk({1'b0, tgt_six}, 8'h10);
    wr(DECAY_OFFSET, 8'h00);
    @(posedge clk) pin3 <= 1'b0;
    wait_cyc(4);
    chk({7'h00, slewing}, 8'h01);
    chk({7'h00, s25}, 8'h00);
    chk({7'h00, s25_six}, 8'h01);
    wait_cyc(6000);
    chk({7'h00, slewing}, 8'h00);
    chk({1'b0, reg_code}, 8'h10);
    // Mid-run reset must bring back the factory image
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(DECAY_OFFSET, DECAY_RESET);
    rd(SLEEP_OFFSET, SLEEP_RESET);
    chk({1'b0, reg_code}, {1'b0, NORMAL_RESET[CODE_MSB:CODE_LSB]});
    chk({7'h00, sleep_on}, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
